/* File: iop_cfg.svh */
// constants for the cpu i/o decode and panel scan block
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH

// ---------------------------------------------------------------
// select assignment and address fields
// ---------------------------------------------------------------
`define IOP_SEL_COL 3'h0
`define IOP_SEL_ROW 3'h1
`define IOP_SEL_MET 3'h2
`define IOP_ACK_A42 3'h1
`define IOP_MISC_A42 3'h2
`define IOP_COL_NONE 3'h7
`define IOP_MASK_BIT 3

// ---------------------------------------------------------------
// register port map and reset values
// ---------------------------------------------------------------
`define IOP_REG_STATUS 2'h0
`define IOP_REG_MASK 2'h1
`define IOP_REG_STATE 2'h2
`define IOP_SEL_RST 8'hff
`define IOP_COL_RST 8'h80
`define IOP_EV_COL 0
`define IOP_EV_MET 1
`define IOP_EV_CNT 2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define IOP_CLK_MHZ 10
`define IOP_MET_US 1000
`define IOP_MET_CYC (`IOP_MET_US * `IOP_CLK_MHZ)

`endif

/* File: iop_pkg.sv */
// types shared by the cpu i/o decode and panel scan block
package iop_pkg;

  // raw pins from the cpu bus and panel, all asynchronous
  typedef struct packed {
    logic [7:0] addr;
    logic req_n;
    logic fetch_n;
    logic rd_n;
    logic wr_n;
    logic [3:0] data;
    logic [5:0] rows;
    logic foot;
    logic carry;
  } iop_pins_t;

  // register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iop_reg_req_t;

  // whole state of the top module
  typedef struct packed {
    logic [7:0] sel_n;
    logic ack_n;
    logic misc_wr_n;
    logic [7:0] column;
    logic [3:0] misc;
    logic met;
    logic [15:0] met_cnt;
    logic cpu_clk;
    logic carry_q;
    logic flag;
    logic [2:0] status;
    logic [2:0] mask;
    logic [7:0] rdata;
    logic [7:0] dout;
    logic dout_oe;
  } iop_state_t;

endpackage

/* File: iop_sync2.sv */
// two flip-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module iop_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // asynchronous bundle in, synchronised bundle out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [1:0][W-1:0] stage_q;

  // stage 0 feeds stage 1 only
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // preload with the pins: no false edge or select after reset
      stage_q <= {d, d};
    end else begin
      stage_q <= {stage_q[0], d};
    end
  end

  assign q = stage_q[1];

endmodule

/* File: iop_panel_io.sv */
// cpu i/o decode, panel switch scan, metronome, clock and interrupt
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "iop_cfg.svh"
module iop_panel_io import iop_pkg::*; #(
  parameter int METRO_CYCLES = `IOP_MET_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // cpu bus pins
  input wire logic [7:0] cpu_addr,
  input wire logic io_request_n,
  input wire logic opcode_fetch_n,
  input wire logic cpu_rd_n,
  input wire logic cpu_wr_n,
  input wire logic [3:0] cpu_data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // decoded selects
  output logic [7:0] io_sel_n,
  output logic column_strobe_n,
  output logic row_read_select_n,
  output logic io_read_strobe_n,
  // switch matrix and footswitch
  output logic [7:0] column_drive,
  input wire logic [5:0] row_in,
  input wire logic footswitch,
  // counter carry, metronome, cpu clock, cpu interrupt
  input wire logic carry_out,
  output logic metronome,
  output logic cpu_clk,
  output logic cpu_int_n,
  // register port and interrupt
  input wire iop_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic irq
);

  iop_pins_t pins_raw;
  iop_pins_t sp;
  iop_state_t q;
  iop_state_t nx;
  logic [7:0] dec_sel_n;
  logic dec_ack_n;
  logic dec_misc_n;
  logic col_take;
  logic met_take;
  logic ack_take;
  logic misc_take;
  logic carry_set;
  logic [2:0] ev;

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  // every pin is two flops deep before any decode looks at it
  assign pins_raw = '{addr: cpu_addr, req_n: io_request_n,
                      fetch_n: opcode_fetch_n, rd_n: cpu_rd_n,
                      wr_n: cpu_wr_n, data: cpu_data_in, rows: row_in,
                      foot: footswitch, carry: carry_out};

  iop_sync2 #(
    .W($bits(iop_pins_t))
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .d(pins_raw),
    .q(sp)
  );

  // ---------------------------------------------------------------
  // i/o cycle decode
  // ---------------------------------------------------------------
  // fetch low marks the interrupt acknowledge cycle: no select then
  always_comb begin
    dec_sel_n = `IOP_SEL_RST;
    if (sp.addr[4] && !sp.req_n && sp.fetch_n) begin
      dec_sel_n[sp.addr[2:0]] = 1'b0;
    end
  end

  // acknowledge read and misc latch write live in the A4-low space
  assign dec_ack_n = !(!sp.req_n && sp.fetch_n && !sp.rd_n &&
                       sp.addr[4:2] == `IOP_ACK_A42);
  assign dec_misc_n = !(!sp.req_n && sp.fetch_n && !sp.wr_n &&
                        sp.addr[4:2] == `IOP_MISC_A42);

  // act once on the leading edge of each select
  assign col_take = q.sel_n[`IOP_SEL_COL] && !dec_sel_n[`IOP_SEL_COL];
  assign met_take = q.sel_n[`IOP_SEL_MET] && !dec_sel_n[`IOP_SEL_MET];
  assign ack_take = q.ack_n && !dec_ack_n;
  assign misc_take = q.misc_wr_n && !dec_misc_n;
  // mask only gates the set; a flag already up stays up
  assign carry_set = sp.carry && !q.carry_q &&
                     !q.misc[`IOP_MASK_BIT];
  assign ev = {carry_set, met_take, col_take};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nx = q;
    nx.sel_n = dec_sel_n;
    nx.ack_n = dec_ack_n;
    nx.misc_wr_n = dec_misc_n;
    nx.carry_q = sp.carry;
    // divide by two: cpu clock runs at half ref_clk
    nx.cpu_clk = !q.cpu_clk;

    // top output held high keeps the driver a plain demultiplexer
    nx.column[7] = 1'b1;
    if (col_take) begin
      nx.column[6:0] = 7'h00;
      if (sp.addr[7:5] != `IOP_COL_NONE) begin
        nx.column[sp.addr[7:5]] = 1'b1;
      end
    end

    // misc latch takes the low nibble of the data bus
    if (misc_take) begin
      nx.misc = sp.data;
    end

    // metronome: retrigger restarts the full width
    if (met_take) begin
      nx.met = 1'b1;
      nx.met_cnt = 16'(METRO_CYCLES - 1);
    end else if (q.met) begin
      if (q.met_cnt == 16'h0000) begin
        nx.met = 1'b0;
      end else begin
        nx.met_cnt = q.met_cnt - 16'h0001;
      end
    end

    // counter flag: a carry in the acknowledge cycle is not lost
    if (carry_set) begin
      nx.flag = 1'b1;
    end else if (ack_take) begin
      nx.flag = 1'b0;
    end

    // row buffer: rows pulled low unless a closed switch lifts them
    nx.dout_oe = !dec_sel_n[`IOP_SEL_ROW];
    nx.dout = 8'h00;
    if (!dec_sel_n[`IOP_SEL_ROW]) begin
      nx.dout = {1'b0, sp.foot, sp.rows};
    end

    // register port: status clears on read, new events win
    nx.rdata = 8'h00;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `IOP_REG_STATUS: nx.rdata = {5'h00, q.status};
        `IOP_REG_MASK: nx.rdata = {5'h00, q.mask};
        `IOP_REG_STATE: nx.rdata = {q.misc, 2'h0, q.met, q.flag};
        default: nx.rdata = 8'h00;
      endcase
    end
    if (reg_req.rd && reg_req.addr == `IOP_REG_STATUS) begin
      nx.status = ev;
    end else begin
      nx.status = q.status | ev;
    end
    if (reg_req.wr && reg_req.addr == `IOP_REG_MASK) begin
      nx.mask = reg_req.wdata[2:0];
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
      q.sel_n <= `IOP_SEL_RST;
      q.ack_n <= 1'b1;
      q.misc_wr_n <= 1'b1;
      q.column <= `IOP_COL_RST;
      q.carry_q <= 1'b1;
    end else begin
      q <= nx;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign io_sel_n = q.sel_n;
  assign column_strobe_n = q.sel_n[`IOP_SEL_COL];
  assign row_read_select_n = q.sel_n[`IOP_SEL_ROW];
  assign io_read_strobe_n = q.ack_n;
  assign column_drive = q.column;
  assign data_out = q.dout;
  assign data_oe = q.dout_oe;
  assign metronome = q.met;
  assign cpu_clk = q.cpu_clk;
  // one source of the shared active-low cpu interrupt line
  assign cpu_int_n = !q.flag;
  assign reg_rdata = q.rdata;
  assign irq = |(q.status & q.mask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  a_select_onehot:
    assert property ($countones(~io_sel_n) <= 1)
    else $error("more than one select low");

  a_select_cause:
    assert property (io_sel_n != 8'hff |->
      $past(sp.addr[4] && !sp.req_n && sp.fetch_n) &&
      !io_sel_n[$past(sp.addr[2:0])])
    else $error("select without a valid io cycle");

  a_column_top_high:
    assert property (column_drive[7])
    else $error("column driver top output low");

  a_column_pick:
    assert property ($fell(column_strobe_n) &&
      $past(sp.addr[7:5]) != 3'h7 |->
      column_drive[$past(sp.addr[7:5])] &&
      $countones(column_drive[6:0]) == 1)
    else $error("column strobe did not pick one column");

  a_column_hold:
    assert property (!$past(reset) && !$fell(column_strobe_n) |->
      $stable(column_drive))
    else $error("column changed without strobe");

  a_rows_on_bus:
    assert property (data_oe |->
      data_out[5:0] == $past(sp.rows) && data_out[6] == $past(sp.foot))
    else $error("row read does not show rows and footswitch");

  a_bus_float:
    assert property (data_oe == !row_read_select_n)
    else $error("data enable not tied to row select");

  a_metro_start:
    assert property ($fell(io_sel_n[`IOP_SEL_MET]) |->
      metronome ##1 (metronome || METRO_CYCLES == 1))
    else $error("metronome did not start on select");

  a_metro_end:
    assert property (!$past(reset) && $fell(metronome) |->
      $past(q.met_cnt) == 16'h0000 && !$past(met_take))
    else $error("metronome ended early");

  a_clock_halves:
    assert property (!$past(reset) |-> cpu_clk != $past(cpu_clk))
    else $error("cpu clock did not toggle");

  a_flag_set:
    assert property ($fell(cpu_int_n) |->
      !$past(q.misc[`IOP_MASK_BIT]) && $past(carry_set))
    else $error("flag set without unmasked carry");

  a_flag_clear:
    assert property (!$past(reset) && $rose(cpu_int_n) |->
      $fell(io_read_strobe_n))
    else $error("flag cleared without acknowledge read");

  a_set_wins:
    assert property (carry_set && ack_take |=> !cpu_int_n)
    else $error("simultaneous acknowledge lost a carry");

endmodule

/* File: iop_cpu_bus.sv */
// cpu i/o bus model that runs port cycles against the panel block
`timescale 1ns/1ps
module iop_cpu_bus (
  // clock
  input wire logic ref_clk,
  // cpu bus pins
  output logic [7:0] cpu_addr,
  output logic io_request_n,
  output logic opcode_fetch_n,
  output logic cpu_rd_n,
  output logic cpu_wr_n,
  output logic [3:0] cpu_data_in,
  // interrupt request line seen by the cpu
  input wire logic cpu_int_n
);
  // ---------------------------------------------------------------
  // idle bus
  // ---------------------------------------------------------------
  initial begin
    cpu_addr = 8'h00;
    io_request_n = 1'b1;
    opcode_fetch_n = 1'b1;
    cpu_rd_n = 1'b1;
    cpu_wr_n = 1'b1;
    cpu_data_in = 4'h0;
  end

  // start an io cycle; pins stand until io_end, so slow cycles are free
  task automatic io_begin(input logic [7:0] a, input logic rd,
                          input logic [3:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_data_in <= d;
    cpu_rd_n <= ~rd;
    cpu_wr_n <= rd;
    io_request_n <= 1'b0;
  endtask

  // release; undriven lines show the inverse, not the stale value
  task automatic io_end();
    @(posedge ref_clk);
    io_request_n <= 1'b1;
    cpu_rd_n <= 1'b1;
    cpu_wr_n <= 1'b1;
    cpu_addr <= ~cpu_addr;
    cpu_data_in <= ~cpu_data_in;
  endtask

  // fetch/acknowledge level
  task automatic set_fetch(input logic f_n);
    @(posedge ref_clk);
    opcode_fetch_n <= f_n;
  endtask
endmodule

/* File: iop_tb.sv */
// self-checking bench for the cpu i/o decode and panel scan block
`timescale 1ns/1ps
module testbench import iop_pkg::*;;
  localparam int METRO = 4;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] row_in = 6'h00;
  logic footswitch = 1'b1;
  logic carry_out = 1'b0;
  iop_reg_req_t reg_req = '0;
  logic [7:0] cpu_addr, data_out, io_sel_n, column_drive, reg_rdata;
  logic [3:0] cpu_data_in;
  logic io_request_n, opcode_fetch_n, cpu_rd_n, cpu_wr_n, data_oe;
  logic column_strobe_n, row_read_select_n, io_read_strobe_n;
  logic metronome, cpu_clk, cpu_int_n, irq;
  int miscompares = 0;
  int check_count = 0;

  always #50 ref_clk = ~ref_clk;

  iop_cpu_bus u_cpu (.ref_clk(ref_clk), .cpu_addr(cpu_addr),
    .io_request_n(io_request_n), .opcode_fetch_n(opcode_fetch_n),
    .cpu_rd_n(cpu_rd_n), .cpu_wr_n(cpu_wr_n),
    .cpu_data_in(cpu_data_in), .cpu_int_n(cpu_int_n));

  iop_panel_io #(.METRO_CYCLES(METRO)) u_dut (.ref_clk(ref_clk),
    .reset(reset), .cpu_addr(cpu_addr), .io_request_n(io_request_n),
    .opcode_fetch_n(opcode_fetch_n), .cpu_rd_n(cpu_rd_n),
    .cpu_wr_n(cpu_wr_n), .cpu_data_in(cpu_data_in),
    .data_out(data_out), .data_oe(data_oe), .io_sel_n(io_sel_n),
    .column_strobe_n(column_strobe_n),
    .row_read_select_n(row_read_select_n),
    .io_read_strobe_n(io_read_strobe_n), .column_drive(column_drive),
    .row_in(row_in), .footswitch(footswitch), .carry_out(carry_out),
    .metronome(metronome), .cpu_clk(cpu_clk), .cpu_int_n(cpu_int_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .irq(irq));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // wait n edges, then step past them so outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req <= '0;
    #1;
    v = reg_rdata;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic c;
    cyc(1);
    check("io_sel_n", io_sel_n, 8'hff);
    check("column_drive", column_drive, 8'h80);
    c = cpu_clk;
    cyc(1);
    check("cpu_clk", {7'h00, cpu_clk ^ c}, 8'h01);
  endtask

  // every column code; 7 leaves only the top output high
  task automatic t_column();
    logic [7:0] e;
    for (int k = 0; k < 8; k++) begin
      e = (k == 7) ? 8'h80 : (8'h80 | (8'h01 << k));
      u_cpu.io_begin({k[2:0], 5'h10}, 1'b0, 4'h0);
      cyc(4);
      check("column_strobe_n", column_strobe_n, 8'h00);
      check("io_sel_n", io_sel_n, 8'hfe);
      check("column_drive", column_drive, e);
      u_cpu.io_end();
      cyc(4);
      check("io_sel_n", io_sel_n, 8'hff);
    end
  endtask

  task automatic t_rows();
    @(posedge ref_clk);
    footswitch <= 1'b0;
    row_in <= 6'h2a;
    u_cpu.io_begin(8'h11, 1'b1, 4'h0);
    cyc(4);
    check("row_read_select_n", row_read_select_n, 8'h00);
    check("data_oe", data_oe, 8'h01);
    check("data_out", data_out, 8'h2a);
    @(posedge ref_clk);
    footswitch <= 1'b1;
    row_in <= 6'h15;
    cyc(3);
    check("data_out", data_out, 8'h55);
    u_cpu.io_end();
    cyc(4);
    check("data_oe", data_oe, 8'h00);
    check("data_out", data_out, 8'h00);
    u_cpu.set_fetch(1'b0);
    u_cpu.io_begin(8'h11, 1'b1, 4'h0);
    cyc(4);
    check("io_sel_n", io_sel_n, 8'hff);
    u_cpu.io_end();
    u_cpu.set_fetch(1'b1);
    cyc(4);
  endtask

  task automatic t_metro();
    int n;
    n = 0;
    u_cpu.io_begin(8'h12, 1'b1, 4'h0);
    cyc(1);
    u_cpu.io_end();
    repeat (20) begin
      cyc(1);
      if (metronome === 1'b1) n++;
    end
    check("metronome_width", n[7:0], METRO[7:0]);
    check("metronome", metronome, 8'h00);
  endtask

  task automatic t_irq();
    logic [7:0] v;
    reg_rd(2'h0, v);
    check("status", v, 8'h03);
    reg_rd(2'h0, v);
    check("status", v, 8'h00);
    reg_wr(2'h1, 8'h04);
    reg_wr(2'h3, 8'hff);
    reg_rd(2'h3, v);
    check("unmapped", v, 8'h00);
    reg_rd(2'h1, v);
    check("mask", v, 8'h04);
    @(posedge ref_clk);
    carry_out <= 1'b1;
    cyc(5);
    check("cpu_int_n", cpu_int_n, 8'h00);
    check("irq", irq, 8'h01);
    reg_rd(2'h0, v);
    check("status", v, 8'h04);
    cyc(1);
    check("irq", irq, 8'h00);
    u_cpu.io_begin(8'h04, 1'b1, 4'h0);
    cyc(4);
    check("io_read_strobe_n", io_read_strobe_n, 8'h00);
    check("cpu_int_n", cpu_int_n, 8'h01);
    check("io_sel_n", io_sel_n, 8'hff);
    u_cpu.io_end();
    u_cpu.io_begin(8'h08, 1'b0, 4'h8);
    cyc(4);
    u_cpu.io_end();
    @(posedge ref_clk);
    carry_out <= 1'b0;
    cyc(3);
    @(posedge ref_clk);
    carry_out <= 1'b1;
    cyc(5);
    check("cpu_int_n", cpu_int_n, 8'h01);
    reg_rd(2'h2, v);
    check("state", v, 8'h80);
  endtask

  // carry edge and acknowledge reach the decode in the same cycle
  task automatic t_set_wins();
    u_cpu.io_begin(8'h08, 1'b0, 4'h0);
    cyc(4);
    u_cpu.io_end();
    @(posedge ref_clk);
    carry_out <= 1'b0;
    cyc(3);
    fork
      u_cpu.io_begin(8'h04, 1'b1, 4'h0);
      begin
        @(posedge ref_clk);
        carry_out <= 1'b1;
      end
    join
    cyc(4);
    check("io_read_strobe_n", io_read_strobe_n, 8'h00);
    check("cpu_int_n", cpu_int_n, 8'h00);
    u_cpu.io_end();
    cyc(4);
    u_cpu.io_begin(8'h04, 1'b1, 4'h0);
    cyc(4);
    check("cpu_int_n", cpu_int_n, 8'h01);
    u_cpu.io_end();
    cyc(4);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_column();
    t_rows();
    t_metro();
    t_irq();
    t_set_wins();
    report_and_stop();
  end

  // whole run is a few hundred cycles; allow far more
  initial begin
    #2000000;
    miscompares++;
    report_and_stop();
  end
endmodule
